// *** include/bsd_pkg.sv ***
package bsd_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [7:0] OFF_MAINT     = 8'h00;
  localparam logic [7:0] OFF_CSR_J     = 8'h04;
  localparam logic [7:0] OFF_BAUD      = 8'h08;
  localparam logic [7:0] OFF_CPU_ERR   = 8'h0c;
  localparam logic [7:0] OFF_CONFIG    = 8'h10;
  localparam logic [7:0] OFF_BASE      = 8'h14;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int MAINT_HALT_BIT    = 3;
  localparam int MAINT_PWRUP_BIT   = 2;
  localparam int CSRJ_BAUD_EN_BIT  = 3;
  localparam int CPU_ERR_HALT_BIT  = 7;
  localparam int CFG_ID_LSB        = 0;
  localparam int CFG_STANDALONE    = 4;
  localparam int CFG_PROM16        = 5;
  localparam int CFG_DMA_CONFLICT  = 6;
  localparam int CFG_BREAK_EN      = 7;
  localparam int CFG_QSIZE_LSB     = 8;

  // ==========================================================================
  // Reset values and decode constants
  // ==========================================================================
  localparam logic [31:0] CSR_J_RESET    = 32'h0000_0000;
  localparam logic [31:0] CPU_ERR_RESET  = 32'h0000_0000;
  localparam logic [2:0]  BAUD_RESET     = 3'h2;
  // 17760100 and 17775400 octal
  localparam logic [21:0] BASE_LOW_ORIGIN  = 22'h3fe040;
  localparam logic [21:0] BASE_HIGH_ORIGIN = 22'h3ffb00;
  // Step 40 octal, jumper-out offset 2000 octal
  localparam logic [21:0] BASE_STEP        = 22'h000020;
  localparam logic [21:0] JUMPER_OUT_ADD   = 22'h000400;
  localparam logic [3:0]  ID_LOW_FIRST     = 4'h2;
  localparam logic [3:0]  ID_HIGH_FIRST    = 4'h8;
  localparam logic [21:0] MASK_16          = 22'h00ffff;
  localparam logic [21:0] MASK_18          = 22'h03ffff;
  localparam logic [21:0] MASK_22          = 22'h3fffff;
  // 173000 and 340 octal; trap vector 4
  localparam logic [15:0] START_PC         = 16'hf600;
  localparam logic [15:0] START_PSW        = 16'h00e0;
  localparam logic [15:0] MONITOR_PSW      = 16'h0000;
  localparam logic [15:0] HALT_TRAP_VECTOR = 16'h0004;
  localparam logic [15:0] BAUD_MAX         = 16'h9600;
  localparam logic [4:0]  PROM_WIDTH_SHORT = 5'h0f;
  localparam logic [4:0]  PROM_WIDTH_LONG  = 5'h10;
  localparam logic [1:0]  SYNC_SETTLE      = 2'h2;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    QSIZE_22,
    QSIZE_18,
    QSIZE_16,
    QSIZE_RSVD
  } bsd_qsize_t;

  typedef enum logic [1:0] {
    ST_LATCH,
    ST_START,
    ST_RUN
  } bsd_state_t;

  // A set bit means the jumper is fitted, except baud_out (1 = out)
  typedef struct packed {
    logic [3:0] id_switch;
    logic       addr_jumper_in;
    logic       dma_ch0_fitted;
    logic       dma_ch1_pct_fitted;
    logic       dma_ch1_ssu_b_fitted;
    logic       break_enable;
    logic       halt_option;
    logic       powerup_option;
    logic       prom16;
    logic [2:0] baud_out;
    bsd_qsize_t qbus_size;
  } bsd_straps_t;

endpackage : bsd_pkg

// *** rtl/bsd_strap_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module bsd_strap_sync (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Raw strap levels
  input  wire bsd_pkg::bsd_straps_t  straps_raw,
  // Frozen copy
  output bsd_pkg::bsd_straps_t       straps_latched,
  output logic                       latched_valid
);

  bsd_pkg::bsd_straps_t meta;
  bsd_pkg::bsd_straps_t stable;
  logic [1:0]           settle;

  // ==========================================================================
  // Two-stage synchroniser
  // ==========================================================================
  // sync the straps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta   <= '0;
      stable <= '0;
    end else begin
      meta   <= straps_raw;
      stable <= meta;
    end
  end

  // ==========================================================================
  // Capture once after reset release
  // ==========================================================================
  // Wait until reset zeros have drained out of the chain before freezing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle <= 2'h0;
    end else if (settle != bsd_pkg::SYNC_SETTLE) begin
      settle <= settle + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      straps_latched <= '0;
      latched_valid  <= 1'b0;
    end else if (!latched_valid && settle == bsd_pkg::SYNC_SETTLE) begin
      straps_latched <= stable;
      latched_valid  <= 1'b1;
    end
  end

endmodule : bsd_strap_sync

`default_nettype wire

// *** rtl/bsd_strap_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none

// Operation
// - ID switch 0 or 1 disables host-bus slave; standalone mode.
// - Base from ID: two banks stepping 40 octal; jumper out adds 2000.
// - DMA channel 0 takes second-unit channel A only if jumper fitted.
// - DMA channel 1 takes at most one source: timer port A or unit B.
// - At most two sources routed; both channel 1 sources never shorted.
// - Console break forwarded only while break-enable strap is fitted.
// - Forwarded break makes processor enter the console debug monitor.
// - HALT-option strap shows read-only in maintenance bit 3.
// - HALT strap fitted: kernel HALT enters debug monitor.
// - HALT strap absent: kernel HALT traps via 4, sets error flag.
// - Power-up strap shows read-only in maintenance bit 2.
// - Power-up strap fitted: start in debug monitor, status word cleared.
// - Power-up strap absent: start at 173000 with status word 340.
// - PROM address is 15 bits without strap, 16 bits with it.
// - Console unit rate resets to code 2, then reloads from baud straps at start-up and reinit.
// - Software changes console rate only while control reg J bit 3 set.
// - 16 or 18 bit host addressing compares only low bits of base.
module bsd_strap_decoder (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Straps
  input  wire bsd_pkg::bsd_straps_t  straps_raw,
  // Host-bus slave decode
  input  wire logic [21:0]           host_addr,
  output logic                       host_slave_enable,
  output logic                       host_addr_hit,
  // DMA routing
  input  wire logic                  ssu2_a_dma_req,
  input  wire logic                  ssu2_b_dma_req,
  input  wire logic                  pct_a_dma_req,
  output logic                       dma_ch0_req,
  output logic                       dma_ch1_req,
  // Processor events
  input  wire logic                  console_break,
  input  wire logic                  kernel_halt,
  input  wire logic                  bus_reinit,
  output logic                       monitor_enter,
  output logic                       halt_trap,
  output logic [15:0]                trap_vector,
  // Start-up
  output logic                       start_valid,
  output logic                       start_in_monitor,
  output logic [15:0]                start_pc,
  output logic [15:0]                start_psw,
  // PROM and console unit rate
  output logic [4:0]                 prom_addr_width,
  output logic [2:0]                 baud_code,
  output logic [15:0]                baud_rate
);

  bsd_pkg::bsd_straps_t  straps;
  bsd_pkg::bsd_state_t   state;
  logic                  straps_valid;
  logic                  standalone;
  logic                  dma_conflict;
  logic [21:0]           base_addr;
  logic [21:0]           size_mask;
  logic [31:0]           csr_j;
  logic [31:0]           cpu_err;
  logic                  aw_held;
  logic                  w_held;
  logic [7:0]            aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  wr_fire;
  logic [31:0]           rd_word;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic reg_known(input logic [7:0] addr);
    reg_known = (addr == bsd_pkg::OFF_MAINT)   || (addr == bsd_pkg::OFF_CSR_J) ||
                (addr == bsd_pkg::OFF_BAUD)    || (addr == bsd_pkg::OFF_CPU_ERR) ||
                (addr == bsd_pkg::OFF_CONFIG)  || (addr == bsd_pkg::OFF_BASE);
  endfunction : reg_known

  function automatic logic [21:0] base_decode(input logic [3:0] id, input logic jin);
    logic [21:0] b;
    b = '0;
    if (id >= bsd_pkg::ID_HIGH_FIRST) begin
      b = bsd_pkg::BASE_HIGH_ORIGIN +
          22'(id - bsd_pkg::ID_HIGH_FIRST) * bsd_pkg::BASE_STEP;
    end else if (id >= bsd_pkg::ID_LOW_FIRST) begin
      b = bsd_pkg::BASE_LOW_ORIGIN +
          22'(id - bsd_pkg::ID_LOW_FIRST) * bsd_pkg::BASE_STEP;
    end
    if (!jin) begin
      b = b + bsd_pkg::JUMPER_OUT_ADD;
    end
    base_decode = b;
  endfunction : base_decode

  bsd_strap_sync u_sync (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .straps_raw     (straps_raw),
    .straps_latched (straps),
    .latched_valid  (straps_valid)
  );

  // ==========================================================================
  // Static decode of latched straps
  // ==========================================================================
  // standalone positions
  assign standalone   = (straps.id_switch < bsd_pkg::ID_LOW_FIRST);
  assign dma_conflict = straps.dma_ch1_pct_fitted && straps.dma_ch1_ssu_b_fitted;

  assign base_addr = base_decode(straps.id_switch, straps.addr_jumper_in);

  always_comb begin
    case (straps.qbus_size)
      bsd_pkg::QSIZE_16: size_mask = bsd_pkg::MASK_16;
      bsd_pkg::QSIZE_18: size_mask = bsd_pkg::MASK_18;
      default:           size_mask = bsd_pkg::MASK_22;
    endcase
  end

  // ==========================================================================
  // Start-up sequencer
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= bsd_pkg::ST_LATCH;
    end else begin
      case (state)
        bsd_pkg::ST_LATCH: begin
          if (straps_valid) begin
            state <= bsd_pkg::ST_START;
          end
        end
        bsd_pkg::ST_START: state <= bsd_pkg::ST_RUN;
        bsd_pkg::ST_RUN:   state <= bsd_pkg::ST_RUN;
        default:           state <= bsd_pkg::ST_LATCH;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_valid      <= 1'b0;
      start_in_monitor <= 1'b0;
      start_pc         <= 16'h0000;
      start_psw        <= 16'h0000;
    end else begin
      start_valid <= (state == bsd_pkg::ST_START);
      if (state == bsd_pkg::ST_START) begin
        start_in_monitor <= straps.powerup_option;
        if (straps.powerup_option) begin
          start_pc  <= 16'h0000;
          start_psw <= bsd_pkg::MONITOR_PSW;
        end else begin
          start_pc  <= bsd_pkg::START_PC;
          start_psw <= bsd_pkg::START_PSW;
        end
      end
    end
  end

  // ==========================================================================
  // Host-bus slave decode
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_slave_enable <= 1'b0;
      host_addr_hit     <= 1'b0;
    end else begin
      host_slave_enable <= straps_valid && !standalone;
      host_addr_hit     <= straps_valid && !standalone &&
                           ((host_addr & size_mask) == (base_addr & size_mask));
    end
  end

  // ==========================================================================
  // DMA request routing
  // ==========================================================================
  // Conflicting channel 1 straps route nothing rather than merge two sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_ch0_req <= 1'b0;
      dma_ch1_req <= 1'b0;
    end else begin
      dma_ch0_req <= straps_valid && straps.dma_ch0_fitted && ssu2_a_dma_req;
      if (!straps_valid || dma_conflict) begin
        dma_ch1_req <= 1'b0;
      end else if (straps.dma_ch1_pct_fitted) begin
        dma_ch1_req <= pct_a_dma_req;
      end else if (straps.dma_ch1_ssu_b_fitted) begin
        dma_ch1_req <= ssu2_b_dma_req;
      end else begin
        dma_ch1_req <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Break and HALT handling
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_enter <= 1'b0;
      halt_trap     <= 1'b0;
      trap_vector   <= 16'h0000;
    end else begin
      monitor_enter <= 1'b0;
      halt_trap     <= 1'b0;
      if (state == bsd_pkg::ST_RUN) begin
        if ((console_break && straps.break_enable) ||
            (kernel_halt && straps.halt_option)) begin
          monitor_enter <= 1'b1;
        end
        if (kernel_halt && !straps.halt_option) begin
          halt_trap   <= 1'b1;
          trap_vector <= bsd_pkg::HALT_TRAP_VECTOR;
        end
      end
    end
  end

  // ==========================================================================
  // PROM width and console rate
  // ==========================================================================
  // PROM width select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prom_addr_width <= bsd_pkg::PROM_WIDTH_SHORT;
    end else begin
      prom_addr_width <= straps.prom16 ? bsd_pkg::PROM_WIDTH_LONG
                                       : bsd_pkg::PROM_WIDTH_SHORT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_code <= bsd_pkg::BAUD_RESET;
    end else if (state == bsd_pkg::ST_START || (bus_reinit && straps_valid)) begin
      baud_code <= straps.baud_out;
    end else if (wr_fire && aw_addr == bsd_pkg::OFF_BAUD && w_strb[0] &&
                 csr_j[bsd_pkg::CSRJ_BAUD_EN_BIT]) begin
      baud_code <= w_data[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_rate <= bsd_pkg::BAUD_MAX >> bsd_pkg::BAUD_RESET;
    end else begin
      baud_rate <= bsd_pkg::BAUD_MAX >> baud_code;
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  // ==========================================================================
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bsd_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_known(aw_addr) ? bsd_pkg::RESP_OKAY : bsd_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_j <= bsd_pkg::CSR_J_RESET;
    end else if (wr_fire && aw_addr == bsd_pkg::OFF_CSR_J && w_strb[0]) begin
      csr_j <= {24'h000000, 4'h0, w_data[bsd_pkg::CSRJ_BAUD_EN_BIT], 3'h0};
    end
  end

  // Write one to clear; a trap in the same cycle keeps the flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_err <= bsd_pkg::CPU_ERR_RESET;
    end else if (state == bsd_pkg::ST_RUN && kernel_halt && !straps.halt_option) begin
      cpu_err[bsd_pkg::CPU_ERR_HALT_BIT] <= 1'b1;
    end else if (wr_fire && aw_addr == bsd_pkg::OFF_CPU_ERR && w_strb[0] &&
                 w_data[bsd_pkg::CPU_ERR_HALT_BIT]) begin
      cpu_err[bsd_pkg::CPU_ERR_HALT_BIT] <= 1'b0;
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  // ==========================================================================
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      bsd_pkg::OFF_MAINT: begin
        rd_word[bsd_pkg::MAINT_HALT_BIT]  = straps.halt_option;
        rd_word[bsd_pkg::MAINT_PWRUP_BIT] = straps.powerup_option;
      end
      bsd_pkg::OFF_CSR_J:   rd_word = csr_j;
      bsd_pkg::OFF_BAUD:    rd_word = {16'h0000, baud_rate[15:3], baud_code};
      bsd_pkg::OFF_CPU_ERR: rd_word = cpu_err;
      bsd_pkg::OFF_CONFIG: begin
        rd_word[bsd_pkg::CFG_ID_LSB +: 4]    = straps.id_switch;
        rd_word[bsd_pkg::CFG_STANDALONE]     = standalone;
        rd_word[bsd_pkg::CFG_PROM16]         = straps.prom16;
        rd_word[bsd_pkg::CFG_DMA_CONFLICT]   = dma_conflict;
        rd_word[bsd_pkg::CFG_BREAK_EN]       = straps.break_enable;
        rd_word[bsd_pkg::CFG_QSIZE_LSB +: 2] = straps.qbus_size;
      end
      bsd_pkg::OFF_BASE:    rd_word = {10'h000, base_addr & size_mask};
      default:              rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= bsd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= reg_known(s_axi_araddr) ? bsd_pkg::RESP_OKAY : bsd_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : bsd_strap_decoder

`default_nettype wire

// *** verif/bsd_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module bsd_checker (
  // Watched ports
  input wire logic        aclk, aresetn, ssu2_a_dma_req, ssu2_b_dma_req, pct_a_dma_req,
  input wire logic        host_slave_enable, host_addr_hit, dma_ch0_req, dma_ch1_req,
  input wire logic        console_break, kernel_halt, monitor_enter, halt_trap, start_valid,
  input wire logic        start_in_monitor, s_axi_bvalid, s_axi_bready,
  input wire logic [15:0] trap_vector, start_pc, start_psw, baud_rate,
  input wire logic [2:0]  baud_code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ========================================
  // Properties
  a_standalone_off: assert property (host_addr_hit |-> host_slave_enable)
    else $error("host hit while slave disabled");
  a_ch0_source: assert property (dma_ch0_req |-> $past(ssu2_a_dma_req))
    else $error("channel 0 request without source");
  a_ch1_source: assert property (dma_ch1_req |-> $past(pct_a_dma_req | ssu2_b_dma_req))
    else $error("channel 1 request without source");
  a_halt_trap: assert property (halt_trap |-> $past(kernel_halt) && trap_vector == 16'h0004)
    else $error("bad halt trap");
  a_monitor_cause: assert property (monitor_enter |-> $past(console_break | kernel_halt))
    else $error("monitor entry without cause");
  a_start_pulse: assert property (start_valid |=> !start_valid)
    else $error("start pulse too long");
  a_start_values: assert property (start_valid |-> (start_in_monitor ?
    {start_pc, start_psw} == 32'h0 : {start_pc, start_psw} == 32'hf600_00e0))
    else $error("bad start values");
  a_baud_rate: assert property ($stable(baud_code) |-> baud_rate == 16'h9600 >> baud_code)
    else $error("rate does not match code");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  c_trap: cover property (halt_trap);
  c_monitor: cover property (monitor_enter);
  c_start_mon: cover property (start_valid && start_in_monitor);
endmodule : bsd_checker
bind bsd_strap_decoder bsd_checker u_chk (.*);
`default_nettype wire

// *** verif/bsd_proc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Processor and request sources; commands arrive already edge aligned
module bsd_proc_model (
  // Commands
  input  wire logic [2:0] ev,
  input  wire logic [2:0] dreq,
  // Far side pins
  output logic            console_break, kernel_halt, bus_reinit,
  output logic            ssu2_a_dma_req, pct_a_dma_req, ssu2_b_dma_req
);
  assign {bus_reinit, kernel_halt, console_break}        = ev;
  assign {ssu2_b_dma_req, pct_a_dma_req, ssu2_a_dma_req} = dreq;
endmodule : bsd_proc_model
`default_nettype wire

// *** verif/bsd_strap_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module bsd_strap_decoder_tb;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [21:0] host_addr = 22'h0;
  logic [2:0]  ev = 3'h0, dreq = 3'h0;
  bsd_pkg::bsd_straps_t straps_raw = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic host_slave_enable, host_addr_hit, dma_ch0_req, dma_ch1_req, monitor_enter, halt_trap;
  logic start_valid, start_in_monitor, console_break, kernel_halt, bus_reinit;
  logic ssu2_a_dma_req, ssu2_b_dma_req, pct_a_dma_req;
  logic [15:0] trap_vector, start_pc, start_psw, baud_rate;
  logic [4:0]  prom_addr_width;
  logic [2:0]  baud_code;
  int miscompares = 0, comparisons = 0, seed = 76, n;
  logic [33:0] q[$];
  always #2.5 aclk = ~aclk;
  bsd_strap_decoder DUT (.*);
  bsd_proc_model u_proc (.*);
  // ========================================
  // Checking and closing
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // Read and write results land here, oldest note first
  always @(negedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      chk(s_axi_bresp, q.pop_front());
    end
  end
  // ========================================
  // Drivers
  task automatic bus(input bit w, input logic [7:0] a, input logic [33:0] e);
    logic [4:0] h;
    q.push_back(w ? 34'(e[33:32]) : e);
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= e[31:0];
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 40; n++) begin
      #1 h = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
        s_axi_bvalid & s_axi_bready, s_axi_arvalid & s_axi_arready, s_axi_rvalid & s_axi_rready};
      if (!(s_axi_awvalid | s_axi_wvalid | s_axi_bready | s_axi_arvalid | s_axi_rready)) break;
      @(posedge aclk);
      if (h[4]) s_axi_awvalid <= 1'b0;
      if (h[3]) s_axi_wvalid <= 1'b0;
      if (h[2]) s_axi_bready <= 1'b0;
      if (h[1]) s_axi_arvalid <= 1'b0;
      if (h[0]) s_axi_rready <= 1'b0;
    end
    if (n == 40) begin
      miscompares++;
      summarize();
    end
  endtask : bus
  task automatic pulse(input logic [2:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 3'h0;
    #1;
  endtask : pulse
  task automatic run_cfg(input bsd_pkg::bsd_straps_t st, input logic [21:0] base);
    logic [2:0] r;
    @(posedge aclk);
    straps_raw <= st;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    for (n = 0; n < 20 && start_valid !== 1'b1; n++) #5;
    if (n == 20) begin
      miscompares++;
      summarize();
    end
    chk({start_in_monitor, start_pc, start_psw}, st.powerup_option ? {1'b1, 32'h0} :
      {1'b0, bsd_pkg::START_PC, bsd_pkg::START_PSW});
    chk(prom_addr_width, st.prom16 ? 5'h10 : 5'h0f);
    // Rate register trails the code by one cycle
    #5 chk({baud_code, baud_rate}, {st.baud_out, 16'h9600 >> st.baud_out});
    chk(host_slave_enable, st.id_switch > 4'h1);
    bus(0, bsd_pkg::OFF_MAINT, {st.halt_option, st.powerup_option, 2'b00});
    bus(0, bsd_pkg::OFF_BASE, base);
    bus(0, 8'h40, {2'b10, 32'h0});
    bus(1, 8'h40, {2'b10, 32'h0});
    @(posedge aclk);
    host_addr <= base;
    repeat (2) @(posedge aclk);
    #1 chk(host_addr_hit, st.id_switch > 4'h1);
    for (int i = 0; i < 16; i++) begin
      @(posedge aclk);
      r = 3'($random(seed));
      dreq <= r;
      @(posedge aclk);
      #1 chk({dma_ch0_req, dma_ch1_req}, {r[0] & st.dma_ch0_fitted,
        st.dma_ch1_pct_fitted ? r[1] & !st.dma_ch1_ssu_b_fitted : r[2] & st.dma_ch1_ssu_b_fitted});
    end
    pulse(3'b010);
    chk({monitor_enter, halt_trap}, {st.halt_option, !st.halt_option});
    bus(0, bsd_pkg::OFF_CPU_ERR, {!st.halt_option, 7'h0});
    bus(1, bsd_pkg::OFF_CPU_ERR, 34'h80);
    bus(0, bsd_pkg::OFF_CPU_ERR, 34'h0);
    pulse(3'b001);
    chk(monitor_enter, st.break_enable);
    bus(1, bsd_pkg::OFF_BAUD, 34'h5);
    chk(baud_code, st.baud_out);
    bus(1, bsd_pkg::OFF_CSR_J, 34'h8);
    bus(1, bsd_pkg::OFF_BAUD, 34'h5);
    chk(baud_code, 3'h5);
    pulse(3'b100);
    #5 chk(baud_code, st.baud_out);
  endtask : run_cfg
  // ========================================
  // Main sequence: upper bank, jumper out, 16 bit; then standalone with all but channel 0, PROM and baud straps fitted
  initial begin
    run_cfg({4'hf, 8'b0101_0001, 3'b001, 2'h2}, 22'h00ffe0);
    run_cfg({4'h1, 8'b1011_1110, 3'b111, 2'h0}, 22'h0);
    summarize();
  end
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
endmodule : bsd_strap_decoder_tb
`default_nettype wire
